// *** mpc_pkg.sv ***
/*
 mpc_pkg: constants and enumerations of the preset counter.
 assumes: a 10 MHz system clock; values are six-digit unsigned integers.
*/
package mpc_pkg;
	// ********************
	// timing
	// ********************
	localparam int CLK_HZ       = 10_000_000;
	localparam int RATE_LO_HZ   = 30;
	localparam int RATE_HI_HZ   = 5000;
	localparam int RATE_LO_CYC  = CLK_HZ / (2 * RATE_LO_HZ);
	localparam int RATE_HI_CYC  = CLK_HZ / (2 * RATE_HI_HZ);
	localparam int RST_LONG_MS  = 20;
	localparam int RST_SHORT_MS = 1;
	localparam int RST_LONG_CYC = (RST_LONG_MS * (CLK_HZ / 1000));
	localparam int RST_SHORT_CYC = (RST_SHORT_MS * (CLK_HZ / 1000));
	localparam int MS_CYC       = CLK_HZ / 1000;
	// ********************
	// values
	// ********************
	localparam int VW = 20;
	localparam logic [19:0] FULL_SCALE = 20'hF423F;
	localparam logic [19:0] ONE_MS     = 20'h00001;
	localparam logic [9:0]  FRAC_ONE   = 10'h3E8;
	// ********************
	// enumerations
	// ********************
	typedef enum logic [2:0] {
		CFG_ONE   = 3'h0,
		CFG_TWO   = 3'h1,
		CFG_TOTAL = 3'h3,
		CFG_BATCH = 3'h2,
		CFG_DUAL  = 3'h6,
		CFG_TACH  = 3'h7
	} mpc_cfg_t;
	typedef enum logic [2:0] {
		IN_UP   = 3'h0,
		IN_DOWN = 3'h1,
		IN_UDA  = 3'h2,
		IN_UDB  = 3'h3,
		IN_UDC  = 3'h4
	} mpc_inmode_t;
	typedef enum logic [3:0] {
		OM_N = 4'h0, OM_F = 4'h1, OM_C = 4'h2, OM_R = 4'h3,
		OM_K1 = 4'h4, OM_P = 4'h5, OM_Q = 4'h6, OM_A = 4'h7,
		OM_K2 = 4'h8, OM_D = 4'h9, OM_L = 4'hA, OM_H = 4'hB
	} mpc_outmode_t;
	typedef enum logic [2:0] {
		KP_ONE = 3'h1, KP_TWO = 3'h2, KP_THREE = 3'h3,
		KP_FOUR = 3'h4, KP_FIVE = 3'h5
	} mpc_kp_t;
endpackage : mpc_pkg

// *** mpc_filter.sv ***
/*
 mpc_filter: two-flop synchroniser and level-width filter for one pin.
 assumes: the pin is asynchronous; widths are given in clock cycles.
*/
`timescale 1ns/1ps
module mpc_filter #(
	parameter int LONG_W  = 1000,
	parameter int SHORT_W = 100
) (
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic pin_i,
	input  wire logic long_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	localparam int CW = 18;
	if (LONG_W >= 2**CW || SHORT_W < 1 || LONG_W < 1)
	begin : g_chk
		$error("mpc_filter: width out of range");
	end
	logic          s1_reg, s2_reg;
	logic          lvl_reg, lvl_next;
	logic          rise_reg, rise_next, fall_reg, fall_next;
	logic [CW-1:0] cnt_reg, cnt_next, lim;

	// chatter shorter than the limit never reaches the level
	always_comb
	begin
		lim = long_i ? CW'(LONG_W) : CW'(SHORT_W);
		lvl_next = lvl_reg;
		cnt_next = '0;
		rise_next = 1'b0;
		fall_next = 1'b0;
		if (s2_reg != lvl_reg)
		begin
			cnt_next = cnt_reg + 1'b1;
			if (cnt_next >= lim)
			begin
				lvl_next = s2_reg;
				cnt_next = '0;
				rise_next = s2_reg;
				fall_next = !s2_reg;
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			lvl_reg <= 1'b0;
			cnt_reg <= '0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			lvl_reg <= lvl_next;
			cnt_reg <= cnt_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
		end
	end
	assign level_o = lvl_reg;
	assign rise_o = rise_reg;
	assign fall_o = fall_reg;

	property p_width;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		(lvl_reg != $past(lvl_reg)) |-> ($past(cnt_reg) + 1 >= $past(lim));
	endproperty
	a_width: assert property (p_width) // [RQ19]
		else $error("level changed before the width limit");
endmodule : mpc_filter

// *** mpc_oneshot.sv ***
/*
 mpc_oneshot: millisecond one-shot timer with its own tick divider.
 assumes: start and clear are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module mpc_oneshot #(
	parameter int MS_CYCLES = 10000
) (
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        start_i,
	input  wire logic        clear_i,
	input  wire logic [19:0] time_ms_i,
	output logic             done_o
);
	import mpc_pkg::*;
	if (MS_CYCLES < 2 || MS_CYCLES >= 2**16)
	begin : g_chk
		$error("mpc_oneshot: tick count out of range");
	end
	typedef enum logic {OS_IDLE = 1'b0, OS_RUN = 1'b1} mpc_os_t;
	mpc_os_t     st_reg, st_next;
	logic [15:0] tick_reg, tick_next;
	logic [19:0] left_reg, left_next;
	logic        done_reg, done_next;

	always_comb
	begin
		st_next = st_reg;
		tick_next = tick_reg;
		left_next = left_reg;
		done_next = 1'b0;
		case (st_reg)
		OS_IDLE:
		begin
			tick_next = '0;
			left_next = time_ms_i;
			if (start_i && time_ms_i != '0)
				st_next = OS_RUN;
		end
		OS_RUN:
		begin
			tick_next = tick_reg + 1'b1;
			if (tick_reg == 16'(MS_CYCLES - 1))
			begin
				tick_next = '0;
				left_next = left_reg - ONE_MS;
				if (left_reg == ONE_MS)
				begin
					done_next = 1'b1; // [RQ24]
					st_next = OS_IDLE;
				end
			end
			if (clear_i)
			begin
				done_next = 1'b0;
				st_next = OS_IDLE;
			end
		end
		default: st_next = OS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			st_reg <= OS_IDLE;
			tick_reg <= '0;
			left_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			tick_reg <= tick_next;
			left_reg <= left_next;
			done_reg <= done_next;
		end
	end
	assign done_o = done_reg;

	property p_expire;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		(st_reg == OS_RUN && !clear_i && left_reg == ONE_MS
			&& tick_reg == 16'(MS_CYCLES - 1)) |=> done_o;
	endproperty
	a_expire: assert property (p_expire) // [RQ24]
		else $error("one-shot did not expire on time");
endmodule : mpc_oneshot

// *** mpc_counter.sv ***
/*
 mpc_counter: multi-configuration preset counter with filtered inputs.
 assumes: field pins are asynchronous; panel keys and settings are
 single-clock signals, keys as one-cycle pulses.
*/
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: outside dual and tachometer, primary reset clears value and outputs (batch output kept), blocks counting
// RQ2: reset lamp lit by primary reset, by secondary alone only in tachometer
// RQ3: dual: primary reset clears and blocks only channel a
// RQ4: one- and two-stage ignore the secondary reset
// RQ5: total: secondary reset clears and holds the total at zero
// RQ6: batch: secondary reset clears batch count and batch output
// RQ7: dual: secondary reset clears and blocks channel b
// RQ8: outside dual and tachometer, input mode decides how the two pulses count
// RQ9: dual: each pulse input counts its own value upward
// RQ10: reset loads zero, or the preset in down mode
// RQ11: outputs act per output mode when the value reaches its preset
// RQ12: twelve output modes exist
// RQ13: tachometer: resets freeze value and outputs, lamp lit, b unused
// RQ14: key protection lamp and five levels gating panel keys
// RQ15: input modes up, down and up/down a, b, c
// RQ16: dual value is sum or difference; difference only in four modes
// RQ17: second one-shot time programmable, only in seven modes
// RQ18: first one-shot in four modes; zero holds, except in K-2
// RQ19: one selectable count rate filters both pulse inputs
// RQ20: one selectable minimum width filters both reset inputs
// RQ21: each pulse is scaled by a prescale factor
// RQ22: batch counts completions, batch output at batch preset
// RQ23: value wraps to zero past full scale
// RQ24: one-shots timed by a millisecond tick from the clock
module mpc_counter #(
	parameter int RATE_LO_W  = mpc_pkg::RATE_LO_CYC,
	parameter int RATE_HI_W  = mpc_pkg::RATE_HI_CYC,
	parameter int RST_LONG_W = mpc_pkg::RST_LONG_CYC,
	parameter int RST_SHRT_W = mpc_pkg::RST_SHORT_CYC,
	parameter int MS_CYCLES  = mpc_pkg::MS_CYC
) (
	input  wire logic                 ref_clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 pulse_in_a_i,
	input  wire logic                 pulse_in_b_i,
	input  wire logic                 reset_first_i,
	input  wire logic                 reset_second_i,
	input  wire mpc_pkg::mpc_cfg_t    config_i,
	input  wire mpc_pkg::mpc_inmode_t in_mode_i,
	input  wire mpc_pkg::mpc_outmode_t out_mode_i,
	input  wire logic                 calc_sub_i,
	input  wire logic                 rate_low_i,
	input  wire logic                 reset_width_long_i,
	input  wire logic [6:0]           prescale_whole_i,
	input  wire logic [9:0]           prescale_frac_i,
	input  wire logic [19:0]          preset_first_i,
	input  wire logic [19:0]          preset_second_i,
	input  wire logic [19:0]          batch_preset_i,
	input  wire logic [19:0]          pulse_time_first_i,
	input  wire logic [19:0]          pulse_time_second_i,
	input  wire logic                 protect_en_i,
	input  wire mpc_pkg::mpc_kp_t     protect_level_i,
	input  wire logic                 key_reset_i,
	input  wire logic                 key_updown_i,
	input  wire logic                 key_display_i,
	input  wire logic                 key_mode_i,
	output logic                      control_out_first_o,
	output logic                      control_out_second_o,
	output logic                      reset_led_o,
	output logic                      protect_led_o,
	output logic [19:0]               present_value_o,
	output logic [19:0]               present_value_b_o,
	output logic signed [21:0]        dual_value_o,
	output logic [19:0]               total_value_o,
	output logic [19:0]               batch_value_o,
	output logic                      key_updown_grant_o,
	output logic                      key_display_grant_o,
	output logic                      key_mode_grant_o
);
	import mpc_pkg::*;

	// ********************
	// helpers
	// ********************
	function automatic logic [19:0] add_w(input logic [19:0] v,
		input logic [7:0] s);
		logic [20:0] sum;
		sum = {1'b0, v} + 21'(s);
		if (sum > {1'b0, FULL_SCALE})
			sum = sum - {1'b0, FULL_SCALE} - 21'h1; // [RQ23]
		return sum[19:0];
	endfunction : add_w

	function automatic logic [19:0] sub_w(input logic [19:0] v,
		input logic [7:0] s);
		logic [20:0] d;
		d = {1'b0, v} - 21'(s);
		if (v < 20'(s))
			d = d + {1'b0, FULL_SCALE} + 21'h1;
		return d[19:0];
	endfunction : sub_w

	// fraction in thousandths carries into the whole step
	function automatic logic [17:0] scale(input logic [9:0] f);
		logic [10:0] fs;
		logic        c;
		fs = {1'b0, f} + {1'b0, prescale_frac_i};
		c = (fs >= {1'b0, FRAC_ONE});
		if (c)
			fs = fs - {1'b0, FRAC_ONE};
		return {({1'b0, prescale_whole_i} + {7'h00, c}), fs[9:0]};
	endfunction : scale

	function automatic logic is_shot2(input mpc_outmode_t m);
		return m inside {OM_C, OM_R, OM_K1, OM_P, OM_Q, OM_A, OM_K2};
	endfunction : is_shot2

	// ********************
	// input conditioning
	// ********************
	logic a_rise, a_fall, b_lvl, b_rise, ra_lvl, rb_lvl;

	mpc_filter #(.LONG_W(RATE_LO_W), .SHORT_W(RATE_HI_W)) u_fa (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.pin_i(pulse_in_a_i), .long_i(rate_low_i), // [RQ19]
		.level_o(), .rise_o(a_rise), .fall_o(a_fall));
	mpc_filter #(.LONG_W(RATE_LO_W), .SHORT_W(RATE_HI_W)) u_fb (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.pin_i(pulse_in_b_i), .long_i(rate_low_i), // [RQ19]
		.level_o(b_lvl), .rise_o(b_rise), .fall_o());
	mpc_filter #(.LONG_W(RST_LONG_W), .SHORT_W(RST_SHRT_W)) u_fr1 (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.pin_i(reset_first_i), .long_i(reset_width_long_i), // [RQ20]
		.level_o(ra_lvl), .rise_o(), .fall_o());
	mpc_filter #(.LONG_W(RST_LONG_W), .SHORT_W(RST_SHRT_W)) u_fr2 (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.pin_i(reset_second_i), .long_i(reset_width_long_i), // [RQ20]
		.level_o(rb_lvl), .rise_o(), .fall_o());

	// ********************
	// one-shot timers
	// ********************
	logic        go1, go2, sh_clr, done1, done2;
	logic [19:0] t1_eff;

	mpc_oneshot #(.MS_CYCLES(MS_CYCLES)) u_os1 (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .start_i(go1),
		.clear_i(sh_clr), .time_ms_i(t1_eff), .done_o(done1));
	mpc_oneshot #(.MS_CYCLES(MS_CYCLES)) u_os2 (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .start_i(go2),
		.clear_i(sh_clr), .time_ms_i(pulse_time_second_i),
		.done_o(done2));

	// ********************
	// counting core
	// ********************
	logic [19:0] pv_reg, pv_next, pvb_reg, pvb_next;
	logic [19:0] tot_reg, tot_next, bat_reg, bat_next;
	logic [9:0]  fa_reg, fa_next, fb_reg, fb_next;
	logic signed [21:0] dual_reg, dual_next;
	logic        o1_reg, o1_next, o2_reg, o2_next;
	logic        led_reg, led_next, kpl_reg, kpl_next;
	logic        gud_reg, gud_next, gdi_reg, gdi_next;
	logic        gmo_reg, gmo_next;
	logic        dual_m, tach_m, two_m, bat_m, down_m, kres;
	logic        ev_a, dn_a, hit1, hitf, sh1_en, sh2_en, sub_en;
	logic [17:0] sa, sb;
	logic [19:0] nv, rst_val;

	always_comb
	begin
		dual_m = (config_i == CFG_DUAL);
		tach_m = (config_i == CFG_TACH);
		two_m = (config_i == CFG_TWO);
		bat_m = (config_i == CFG_BATCH);
		down_m = !dual_m && !tach_m && (in_mode_i == IN_DOWN);
		// protection never blocks the lamp, only the keys
		kres = key_reset_i && (!protect_en_i || protect_level_i == KP_ONE
			|| protect_level_i == KP_THREE); // [RQ14]
		gud_next = key_updown_i && (!protect_en_i
			|| protect_level_i == KP_ONE
			|| protect_level_i == KP_TWO); // [RQ14]
		gdi_next = key_display_i && (!protect_en_i
			|| protect_level_i != KP_FIVE); // [RQ14]
		gmo_next = key_mode_i && !protect_en_i; // [RQ14]
		kpl_next = protect_en_i; // [RQ14]
		// count direction from the selected input mode
		ev_a = a_rise; // [RQ8] [RQ15]
		dn_a = 1'b0;
		case (in_mode_i)
		IN_DOWN: dn_a = 1'b1;
		IN_UDA:  dn_a = b_lvl;
		IN_UDB:
		begin
			ev_a = a_rise ^ b_rise;
			dn_a = b_rise;
		end
		IN_UDC:
		begin
			ev_a = a_rise | a_fall;
			dn_a = a_rise ? b_lvl : !b_lvl;
		end
		default: dn_a = 1'b0;
		endcase
		if (dual_m || tach_m)
		begin
			ev_a = a_rise; // [RQ9]
			dn_a = 1'b0;
		end
		sa = scale(fa_reg); // [RQ21]
		sb = scale(fb_reg); // [RQ21]
		nv = dn_a ? sub_w(pv_reg, sa[17:10]) : add_w(pv_reg, sa[17:10]);
		rst_val = down_m ? (two_m ? preset_second_i : preset_first_i)
			: '0; // [RQ10]
		hit1 = ev_a && nv == preset_first_i; // [RQ11]
		hitf = ev_a && (down_m ? nv == '0
			: nv == (two_m ? preset_second_i : preset_first_i)); // [RQ11]
		t1_eff = (out_mode_i == OM_K2 && pulse_time_first_i == '0)
			? ONE_MS : pulse_time_first_i; // [RQ18]
		sh1_en = (out_mode_i inside {OM_D, OM_L, OM_H, OM_K2})
			&& t1_eff != '0; // [RQ18]
		sh2_en = is_shot2(out_mode_i) && pulse_time_second_i != '0; // [RQ17]
		sub_en = calc_sub_i && (out_mode_i inside
			{OM_K2, OM_D, OM_L, OM_H}); // [RQ16] [RQ12]
		led_next = tach_m ? (ra_lvl || rb_lvl) : ra_lvl; // [RQ2] [RQ13]
		pv_next = pv_reg;
		pvb_next = pvb_reg;
		fa_next = fa_reg;
		fb_next = fb_reg;
		tot_next = tot_reg;
		bat_next = bat_reg;
		o1_next = o1_reg;
		o2_next = o2_reg;
		go1 = 1'b0;
		go2 = 1'b0;
		sh_clr = kres || (ra_lvl && !dual_m && !tach_m);
		if (tach_m)
		begin
			if (!(ra_lvl || rb_lvl) && ev_a) // [RQ13]
			begin
				pv_next = nv;
				fa_next = sa[9:0];
				o1_next = o1_reg || hit1;
				o2_next = o2_reg || hit1;
			end
		end
		else if (dual_m)
		begin
			if (ra_lvl)
			begin
				pv_next = '0; // [RQ3]
				fa_next = '0;
			end
			else if (ev_a)
			begin
				pv_next = add_w(pv_reg, sa[17:10]); // [RQ9]
				fa_next = sa[9:0];
			end
			if (rb_lvl)
			begin
				pvb_next = '0; // [RQ7]
				fb_next = '0;
			end
			else if (b_rise)
			begin
				pvb_next = add_w(pvb_reg, sb[17:10]); // [RQ9]
				fb_next = sb[9:0];
			end
		end
		else if (ra_lvl)
		begin
			pv_next = rst_val; // [RQ1] [RQ10]
			fa_next = '0;
			o1_next = 1'b0;
			if (!bat_m)
				o2_next = 1'b0;
		end
		else if (ev_a)
		begin
			pv_next = nv;
			fa_next = sa[9:0];
			if (config_i == CFG_TOTAL)
				tot_next = dn_a ? sub_w(tot_reg, sa[17:10])
					: add_w(tot_reg, sa[17:10]);
			if (hitf)
			begin
				if (is_shot2(out_mode_i))
					pv_next = rst_val; // restart after completion
				if (bat_m)
					bat_next = add_w(bat_reg, 8'h01); // [RQ22]
			end
			if (two_m)
			begin
				o1_next = o1_reg || hit1; // [RQ11]
				go1 = hit1 && sh1_en; // [RQ18]
				o2_next = o2_reg || hitf;
				go2 = hitf && sh2_en; // [RQ17]
			end
			else if (hitf)
			begin
				o1_next = 1'b1; // [RQ11]
				o2_next = bat_m ? o2_reg : 1'b1;
				go2 = sh2_en; // [RQ17]
			end
		end
		if (dual_m)
		begin
			dual_next = sub_en
				? $signed({2'b00, pv_next}) - $signed({2'b00, pvb_next})
				: $signed({2'b00, pv_next}) + $signed({2'b00, pvb_next});
			if ((ev_a || b_rise) && dual_next == $signed({2'b00,
				preset_first_i}))
			begin
				o1_next = 1'b1; // [RQ11] [RQ16]
				o2_next = 1'b1;
				go2 = sh2_en;
			end
		end
		else
			dual_next = dual_reg;
		// one-shot expiry ends the pulse outputs
		if (done1 && two_m)
			o1_next = 1'b0; // [RQ24]
		if (done2)
		begin
			o2_next = bat_m ? o2_next : 1'b0; // [RQ24]
			o1_next = two_m ? o1_next : 1'b0;
		end
		if (config_i == CFG_TOTAL && rb_lvl) // [RQ4]
			tot_next = '0; // [RQ5]
		if (bat_m)
		begin
			if (rb_lvl)
			begin
				bat_next = '0; // [RQ6]
				o2_next = 1'b0;
			end
			else if (batch_preset_i != '0 && bat_next >= batch_preset_i)
				o2_next = 1'b1; // [RQ22]
		end
		// secondary reset has no branch for the stage configurations
		if (kres)
		begin
			pv_next = rst_val;
			pvb_next = '0;
			fa_next = '0;
			fb_next = '0;
			tot_next = '0;
			bat_next = '0;
			dual_next = '0;
			o1_next = 1'b0;
			o2_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			pv_reg <= '0;
			pvb_reg <= '0;
			fa_reg <= '0;
			fb_reg <= '0;
			tot_reg <= '0;
			bat_reg <= '0;
			dual_reg <= '0;
			o1_reg <= 1'b0;
			o2_reg <= 1'b0;
			led_reg <= 1'b0;
			kpl_reg <= 1'b0;
			gud_reg <= 1'b0;
			gdi_reg <= 1'b0;
			gmo_reg <= 1'b0;
		end
		else
		begin
			pv_reg <= pv_next;
			pvb_reg <= pvb_next;
			fa_reg <= fa_next;
			fb_reg <= fb_next;
			tot_reg <= tot_next;
			bat_reg <= bat_next;
			dual_reg <= dual_next;
			o1_reg <= o1_next;
			o2_reg <= o2_next;
			led_reg <= led_next;
			kpl_reg <= kpl_next;
			gud_reg <= gud_next;
			gdi_reg <= gdi_next;
			gmo_reg <= gmo_next;
		end
	end

	assign control_out_first_o = o1_reg;
	assign control_out_second_o = o2_reg;
	assign reset_led_o = led_reg;
	assign protect_led_o = kpl_reg;
	assign present_value_o = pv_reg;
	assign present_value_b_o = pvb_reg;
	assign dual_value_o = dual_reg;
	assign total_value_o = tot_reg;
	assign batch_value_o = bat_reg;
	assign key_updown_grant_o = gud_reg;
	assign key_display_grant_o = gdi_reg;
	assign key_mode_grant_o = gmo_reg;

	// ********************
	// checks
	// ********************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_rst1;
		(ra_lvl && !dual_m && !tach_m) |=> !o1_reg && pv_reg == $past(rst_val);
	endproperty
	a_rst1: assert property (p_rst1) // [RQ1]
		else $error("primary reset did not clear value and output");
	property p_led;
		(ra_lvl |=> reset_led_o) and
		((rb_lvl && !ra_lvl && !tach_m) |=> !reset_led_o);
	endproperty
	a_led: assert property (p_led) // [RQ2]
		else $error("reset lamp wrong");
	property p_dual_a;
		(dual_m && ra_lvl && !kres) |=> pv_reg == '0 && led_reg;
	endproperty
	a_dual_a: assert property (p_dual_a) // [RQ3]
		else $error("channel a not cleared");
	property p_stage_b;
		(config_i inside {CFG_ONE, CFG_TWO} && rb_lvl && !ra_lvl && !ev_a
			&& !kres) |=> $stable(pv_reg);
	endproperty
	a_stage_b: assert property (p_stage_b) // [RQ4]
		else $error("secondary reset acted in stage mode");
	property p_total;
		(config_i == CFG_TOTAL && rb_lvl)[*2] |=> tot_reg == '0;
	endproperty
	a_total: assert property (p_total) // [RQ5]
		else $error("total not held at zero");
	property p_batch;
		(bat_m && rb_lvl) |=> bat_reg == '0 && !o2_reg;
	endproperty
	a_batch: assert property (p_batch) // [RQ6]
		else $error("batch not cleared");
	property p_dual_b;
		(dual_m && rb_lvl) |=> pvb_reg == '0;
	endproperty
	a_dual_b: assert property (p_dual_b) // [RQ7]
		else $error("channel b not cleared");
	property p_wrap;
		pv_reg <= FULL_SCALE && tot_reg <= FULL_SCALE;
	endproperty
	a_wrap: assert property (p_wrap) // [RQ23]
		else $error("value beyond full scale");
	property p_tach;
		(tach_m && (ra_lvl || rb_lvl) && !kres) |=> $stable(pv_reg)
			&& $stable(o1_reg);
	endproperty
	a_tach: assert property (p_tach) // [RQ13]
		else $error("hold did not freeze");
	property p_kp;
		(protect_en_i && key_mode_i) |=> !key_mode_grant_o;
	endproperty
	a_kp: assert property (p_kp) // [RQ14]
		else $error("mode key passed under protection");

	c_control_out_first: cover property ($rose(o1_reg));
	c_batch: cover property (bat_m && $rose(o2_reg));
	c_dual: cover property (dual_m && b_rise ##1 pvb_reg != '0);
endmodule : mpc_counter

// *** mpc_field.sv ***
/*
 mpc_field: field sensors and reset switches at the counter pins.
 assumes: the bench clock; pins idle low and move at the falling edge.
*/
`timescale 1ns/1ps
module mpc_field (
	input  wire logic ref_clk_i,
	output logic      pin_a_o,
	output logic      pin_b_o,
	output logic      rst_a_o,
	output logic      rst_b_o
);
	logic [3:0] p = 4'h0;
	assign {rst_b_o, rst_a_o, pin_b_o, pin_a_o} = p;
	// ********************
	// drivers
	// ********************
	task automatic drive(input int ch, input int w);
		@(negedge ref_clk_i) p[ch] = 1'b1;
		repeat (w) @(negedge ref_clk_i);
		p[ch] = 1'b0;
		repeat (w) @(negedge ref_clk_i);
	endtask : drive
	// contacts bounce: a one-cycle glitch leads every real pulse
	task automatic pulse(input int ch);
		drive(ch, 1);
		drive(ch, 12);
	endtask : pulse
	task automatic set(input int ch, input logic v);
		@(negedge ref_clk_i) p[ch] = v;
		repeat (20) @(negedge ref_clk_i);
	endtask : set
endmodule : mpc_field

// *** multimode_preset_counter_bench.sv ***
/*
 bench of mpc_counter: integer model of values checked at each result.
 assumes: short filter parameters; inputs move at the falling edge.
*/
`timescale 1ns/1ps
module multimode_preset_counter_bench;
	import mpc_pkg::*;
	logic         ref_clk_i, sys_rst_i, sub, pen, k_rst, k_ud, k_dsp;
	logic         k_mode, pa, pb, ra, rb, o1, o2, led, pled, gu, gd, gm;
	logic         rl, rw;
	mpc_cfg_t     cfg;
	mpc_inmode_t  inm;
	mpc_outmode_t om;
	mpc_kp_t      lvl;
	logic [6:0]   pw;
	logic [9:0]   pf;
	logic [19:0]  sv1, pv, pvb, tot, bat, bsv, t1, t2;
	logic [21:0]  dv;
	logic [2:0]   gs;
	int           bad_count, cmp_count, ma, mb, n;
	mpc_field fld (.ref_clk_i(ref_clk_i), .pin_a_o(pa), .pin_b_o(pb),
		.rst_a_o(ra), .rst_b_o(rb));
	mpc_counter #(.RATE_LO_W(20), .RATE_HI_W(4), .RST_LONG_W(30),
		.RST_SHRT_W(10), .MS_CYCLES(10)) uut (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pulse_in_a_i(pa),
		.pulse_in_b_i(pb), .reset_first_i(ra), .reset_second_i(rb),
		.config_i(cfg), .in_mode_i(inm), .out_mode_i(om),
		.calc_sub_i(sub), .rate_low_i(rl), .reset_width_long_i(rw),
		.prescale_whole_i(pw), .prescale_frac_i(pf),
		.preset_first_i(sv1), .preset_second_i(sv1),
		.batch_preset_i(bsv), .pulse_time_first_i(t1),
		.pulse_time_second_i(t2), .protect_en_i(pen),
		.protect_level_i(lvl), .key_reset_i(k_rst), .key_updown_i(k_ud),
		.key_display_i(k_dsp), .key_mode_i(k_mode),
		.control_out_first_o(o1), .control_out_second_o(o2),
		.reset_led_o(led), .protect_led_o(pled), .present_value_o(pv),
		.present_value_b_o(pvb), .dual_value_o(dv), .total_value_o(tot),
		.batch_value_o(bat), .key_updown_grant_o(gu),
		.key_display_grant_o(gd), .key_mode_grant_o(gm));
	// ********************
	// helpers
	// ********************
	initial
	begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input logic [21:0] s, input logic [21:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic rst_sys(input mpc_cfg_t c);
		cfg = c;
		sys_rst_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		@(negedge ref_clk_i);
		ma = 0;
		mb = 0;
	endtask : rst_sys
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	// a hang of about sixteen times the expected run counts as a mismatch
	initial
	begin
		#2_000_000;
		bad_count++;
		conclude();
	end
	// ********************
	// tests
	// ********************
	initial
	begin
		sys_rst_i = 1'b1;
		{rl, rw, sub, pen, k_rst, k_ud, k_dsp, k_mode} = 8'h00;
		{bsv, t1, t2} = 60'h0;
		cfg = CFG_ONE;
		inm = IN_UP;
		om = OM_N;
		lvl = KP_ONE;
		pw = 7'h01;
		pf = 10'h000;
		sv1 = 20'h00003;
		bad_count = 0;
		cmp_count = 0;
		void'($urandom(32'h579C6250));
		repeat (20) @(negedge ref_clk_i);
		rst_sys(CFG_ONE);
		n = $urandom_range(4, 2);
		sv1 = 20'(n);
		for (int i = 0; i < n; i++)
		begin
			fld.pulse(0);
			ma++;
			chk(pv, 22'(ma));
		end
		chk(o2, 22'h1);
		fld.set(2, 1'b1);
		chk(led, 22'h1);
		chk({o1, o2, pv}, 22'h0);
		fld.pulse(0);
		chk(pv, 22'h0);
		fld.set(2, 1'b0);
		fld.pulse(0);
		fld.set(3, 1'b1);
		chk(led, 22'h0);
		chk(pv, 22'h1);
		fld.set(3, 1'b0);
		rw = 1'b1;
		fld.set(2, 1'b1);
		chk({led, pv}, 22'h1);
		fld.set(2, 1'b0);
		rw = 1'b0;
		$display("one-stage test done");
		sv1 = 20'hF423F;
		rst_sys(CFG_ONE);
		pw = 7'h02;
		pf = 10'h1F4;
		fld.pulse(0);
		chk(pv, 22'h2);
		fld.pulse(0);
		chk(pv, 22'h5);
		rl = 1'b1;
		fld.pulse(0);
		chk(pv, 22'h5);
		rl = 1'b0;
		pw = 7'h01;
		pf = 10'h000;
		$display("prescale test done");
		rst_sys(CFG_TOTAL);
		fld.pulse(0);
		fld.pulse(0);
		chk(tot, 22'h2);
		fld.set(3, 1'b1);
		fld.pulse(0);
		chk(tot, 22'h0);
		chk(pv, 22'h3);
		fld.set(3, 1'b0);
		$display("total test done");
		rst_sys(CFG_DUAL);
		sub = 1'b1;
		fld.pulse(0);
		fld.pulse(0);
		fld.pulse(1);
		chk(pv, 22'h2);
		chk(pvb, 22'h1);
		chk(dv, 22'h3);
		om = OM_D;
		repeat (4) @(negedge ref_clk_i);
		chk(dv, 22'h1);
		fld.set(3, 1'b1);
		fld.pulse(1);
		chk({pv, 2'h0} | pvb, 22'h8);
		fld.set(3, 1'b0);
		fld.set(2, 1'b1);
		fld.pulse(0);
		fld.pulse(1);
		chk(pv, 22'h0);
		chk(dv, 22'h3FFFFF);
		fld.set(2, 1'b0);
		om = OM_N;
		sub = 1'b0;
		$display("dual test done");
		rst_sys(CFG_TACH);
		fld.pulse(0);
		fld.pulse(1);
		chk(pv, 22'h1);
		fld.set(2, 1'b1);
		fld.pulse(0);
		chk({led, pv}, 22'h100001);
		fld.set(2, 1'b0);
		$display("tachometer test done");
		sv1 = 20'h00002;
		{bsv, t2} = {20'h00002, 20'h00003};
		om = OM_C;
		rst_sys(CFG_BATCH);
		fld.pulse(0);
		fld.pulse(0);
		chk({o2, bat}, 22'h1);
		fld.pulse(0);
		fld.pulse(0);
		chk({o2, bat}, 22'h100002);
		chk(o1, 22'h1);
		repeat (40) @(negedge ref_clk_i);
		chk({o2, o1}, 22'h2);
		fld.set(3, 1'b1);
		chk({o2, bat}, 22'h0);
		fld.set(3, 1'b0);
		om = OM_N;
		t2 = 20'h00000;
		$display("batch test done");
		sv1 = 20'h00003;
		inm = IN_DOWN;
		rst_sys(CFG_TWO);
		fld.set(2, 1'b1);
		chk(pv, 22'h3);
		fld.set(2, 1'b0);
		fld.pulse(0);
		chk(pv, 22'h2);
		inm = IN_UP;
		$display("down test done");
		rst_sys(CFG_ONE);
		fld.pulse(0);
		ma = 1;
		pen = 1'b1;
		for (int l = 5; l >= 1; l--)
		begin
			lvl = mpc_kp_t'(l);
			{k_rst, k_ud, k_dsp, k_mode} = 4'hF;
			@(negedge ref_clk_i);
			gs = {gu, gd, gm};
			{k_rst, k_ud, k_dsp, k_mode} = 4'h0;
			repeat (3) @(negedge ref_clk_i);
			ma = (l == 1 || l == 3) ? 0 : ma;
			chk({pled, gs}, {18'h0, 1'b1, l <= 2, l <= 4, 1'b0});
			chk(pv, 22'(ma));
		end
		pen = 1'b0;
		@(negedge ref_clk_i) k_mode = 1'b1;
		@(negedge ref_clk_i);
		gs[0] = gm;
		k_mode = 1'b0;
		chk({pled, gs[0]}, 22'h1);
		$display("key protection test done");
		conclude();
	end
endmodule : multimode_preset_counter_bench
